// ---- shared/pvic_pkg.sv ----
// constants, types and field tables for the vectored interrupt controller
// assumes a single hclk domain; one register word per aligned 32-bit AHB-Lite slot
package pvic_pkg;
    localparam int NUM_EVT = 13;
    localparam int NUM_SOFT = 7;
    localparam int NUM_HWTRAP = 5;
    localparam int NUM_SWTRAP = 16;
    // register byte offsets
    localparam logic [7:0] OFS_EN_LOW = 8'h00;
    localparam logic [7:0] OFS_EN_HIGH = 8'h04;
    localparam logic [7:0] OFS_PA_BASE = 8'h08;
    localparam logic [7:0] OFS_PA_LAST = 8'h24;
    localparam logic [7:0] OFS_SOFT_REQ = 8'h28;
    localparam logic [7:0] OFS_SOFT_EN = 8'h2C;
    localparam logic [7:0] OFS_STATUS = 8'h30;
    localparam logic [7:0] OFS_CTRL = 8'h34;
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam int PA_MISSING = 3;
    localparam int GLOBAL_EN_BIT = 7;
    localparam int CTRL_T2_BAUD = 0;
    localparam int CTRL_EXT0_LVL = 1;
    localparam int CTRL_EXT1_LVL = 2;
    localparam int EN_EXT0_BIT = 0;
    localparam int EN_EXT1_BIT = 2;
    localparam int EVT_TIMER2 = 4;
    localparam logic [3:0] LVL_SOFT_TOP = 4'h7;
    localparam logic [3:0] LVL_EVT_LOW = 4'h9;
    // per event: enable bit in {high,low} and level field slot (same index)
    localparam logic [12:0][3:0] EVT_SLOT = {4'hF, 4'hE, 4'hD, 4'hC, 4'hB, 4'h9,
        4'h8, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
    localparam logic [12:0][4:0] EVT_RANK = {5'h11, 5'h10, 5'h0F, 5'h0E, 5'h0D,
        5'h0B, 5'h0A, 5'h07, 5'h06, 5'h05, 5'h04, 5'h03, 5'h02};
    localparam logic [12:0][15:0] EVT_VEC = {16'h00BC, 16'h00B8, 16'h00B4,
        16'h00B0, 16'h00AC, 16'h00A4, 16'h00A0, 16'h0094, 16'h0090, 16'h008C,
        16'h0088, 16'h0084, 16'h0080};
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_STEP = 16'h0004;
    localparam logic [15:0] VEC_SWTRAP_BASE = 16'h0040;
    localparam logic [15:0] VEC_SOFT_BASE = 16'h0100;

    typedef enum logic [2:0] {
        K_NONE = 3'b000,
        K_RESET = 3'b001,
        K_HWTRAP = 3'b010,
        K_SWTRAP = 3'b011,
        K_EVENT = 3'b100,
        K_SOFT = 3'b101
    } pvic_kind_t;

    typedef enum logic [1:0] {
        S_IDLE = 2'b00,
        S_OFFER = 2'b01,
        S_GAP = 2'b10
    } pvic_fsm_t;

    // request handed to the core sequencer
    typedef struct packed {
        logic req;
        pvic_kind_t kind;
        logic [4:0] idx;
        logic [3:0] level;
        logic [15:0] vector;
    } pvic_offer_t;

    // answer from the core sequencer
    typedef struct packed {
        logic ack;
        logic [3:0] level;
    } pvic_core_t;

    // non-maskable sources, one-cycle pulses
    typedef struct packed {
        logic reset_req;
        logic [4:0] hw_trap;
        logic sw_trap;
        logic [3:0] sw_trap_num;
    } pvic_exc_t;
endpackage : pvic_pkg

// ---- core/pvic_event_arb.sv ----
// ranks the maskable events and software interrupts against the core level
// assumes registered inputs on hclk; combinational, hclk only clocks the checks
`timescale 1ns/1ps
`default_nettype none
module pvic_event_arb (
    input wire logic hclk,
    input wire logic [12:0] evt_req,
    input wire logic [15:0] evt_en,
    input wire logic [7:0][7:0] prio,
    input wire logic [3:0] core_level,
    input wire logic [6:0] soft_req,
    input wire logic [6:0] soft_en,
    output logic found,
    output pvic_pkg::pvic_kind_t kind,
    output logic [4:0] idx,
    output logic [3:0] level
);
    import pvic_pkg::*;

    logic [12:0] elig;
    logic [12:0][3:0] lvl;
    logic [12:0] beaten;

    // per event level and eligibility
    genvar g;
    generate
        for (g = 0; g < NUM_EVT; g++) begin : g_evt
            localparam int SL = int'(EVT_SLOT[g]);
            logic [2:0] field;
            assign field = prio[SL / 2][(SL % 2) * 4 +: 3];
            assign lvl[g] = {1'b1, field};
            // zero field and clear enables both keep the event out
            assign elig[g] = evt_req[g] && evt_en[SL] && evt_en[GLOBAL_EN_BIT]
                && (field != 3'h0) && (lvl[g] > core_level);
        end
    endgenerate

    // level first, rank on a tie; any event beats any software interrupt
    always_comb begin
        found = 1'b0;
        kind = K_NONE;
        idx = 5'h00;
        level = 4'h0;
        for (int i = 0; i < NUM_EVT; i++) begin
            if (elig[i] && (!found || lvl[i] > level)) begin
                found = 1'b1;
                kind = K_EVENT;
                idx = 5'(i);
                level = lvl[i];
            end
        end
        for (int n = NUM_SOFT - 1; n >= 0; n--) begin
            if (!found && soft_req[n] && soft_en[n] && 4'(n + 1) > core_level) begin
                found = 1'b1;
                kind = K_SOFT;
                idx = 5'(n);
                level = 4'(n + 1);
            end
        end
    end

    // helper for checks: some eligible event outranks the winner
    always_comb begin
        beaten = '0;
        for (int i = 0; i < NUM_EVT; i++) begin
            beaten[i] = elig[i] && kind == K_EVENT && (lvl[i] > level
                || (lvl[i] == level && EVT_RANK[i] < EVT_RANK[idx[3:0]]));
        end
    end

    a_best_level: assert property (@(posedge hclk)
        kind == K_EVENT |-> beaten == '0)
        else $error("event arbitration passed over a better event");
    a_soft_below: assert property (@(posedge hclk)
        kind == K_SOFT |-> elig == '0 && level <= LVL_SOFT_TOP)
        else $error("software interrupt won against an event");
endmodule : pvic_event_arb
`default_nettype wire

// ---- core/pvic_top.sv ----
// vectored interrupt controller: AHB-Lite registers, non-maskable latches,
// arbitration and the request/acknowledge exchange with the core sequencer
// assumes peripheral flags and core signals are on hclk; pins are asynchronous
`timescale 1ns/1ps
`default_nettype none
module pvic_top (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic [12:0] evt_flags,
    input wire pvic_pkg::pvic_exc_t exc_in,
    input wire pvic_pkg::pvic_core_t core_in,
    output pvic_pkg::pvic_offer_t offer_out,
    input wire logic timer2_capture_pin,
    input wire logic ext0_pin_n,
    input wire logic ext1_pin_n,
    input wire logic power_down,
    output logic wake_request
);
    import pvic_pkg::*;

    typedef struct packed {
        logic [7:0] en_low;
        logic [7:0] en_high;
        logic [7:0][7:0] pa;
        logic [6:0] soft_req;
        logic [6:0] soft_en;
        logic [2:0] ctrl;
        logic ph_valid;
        logic ph_write;
        logic [7:0] ph_addr;
        logic [31:0] rdata;
        logic [2:0] pin_s1;
        logic [2:0] pin_s2;
        logic t2_prev;
        logic t2_ext_flag;
        logic rst_pend;
        logic [4:0] hw_pend;
        logic [15:0] sw_pend;
        pvic_fsm_t fsm;
        pvic_offer_t offer;
        logic wake;
    } pvic_state_t;

    pvic_state_t s;
    pvic_state_t next_s;
    logic [12:0] evt_req;
    logic arb_found;
    pvic_kind_t arb_kind;
    logic [4:0] arb_idx;
    logic [3:0] arb_level;
    pvic_offer_t cand;
    logic acked;
    logic t2_fall;

    ////////////////////////////////////////////////////////////////////////
    // bus answers: zero wait, always OKAY; ce low stalls the bus
    assign hreadyout = ce;
    assign hresp = 1'b0;
    assign hrdata = s.rdata;
    assign offer_out = s.offer;
    assign wake_request = s.wake;

    // timer 2 request also fed by the capture pin flag
    assign evt_req = evt_flags | (13'(s.t2_ext_flag) << EVT_TIMER2);
    assign t2_fall = s.t2_prev && !s.pin_s2[0];
    assign acked = s.fsm == S_OFFER && core_in.ack;

    pvic_event_arb u_arb (
        .hclk(hclk),
        .evt_req(evt_req),
        .evt_en({s.en_high, s.en_low}),
        .prio(s.pa),
        .core_level(core_in.level),
        .soft_req(s.soft_req),
        .soft_en(s.soft_en),
        .found(arb_found),
        .kind(arb_kind),
        .idx(arb_idx),
        .level(arb_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // register read word, address taken in the address phase
    function automatic logic [31:0] read_word(input pvic_state_t r, input logic [7:0] a,
        input logic [12:0] rq);
        logic [31:0] w;
        logic [7:0] k;
        w = 32'h0000_0000;
        k = (a - OFS_PA_BASE) >> 2;
        if (a == OFS_EN_LOW) w[7:0] = r.en_low;
        else if (a == OFS_EN_HIGH) w[7:0] = r.en_high;
        else if (a >= OFS_PA_BASE && a <= OFS_PA_LAST) w[7:0] = r.pa[k[2:0]];
        else if (a == OFS_SOFT_REQ) w[6:0] = r.soft_req;
        else if (a == OFS_SOFT_EN) w[6:0] = r.soft_en;
        else if (a == OFS_CTRL) w[2:0] = r.ctrl;
        else if (a == OFS_STATUS) begin
            w[12:0] = rq;
            w[13] = r.t2_ext_flag;
            w[19:16] = r.offer.level;
            w[20] = r.offer.req;
            w[23:21] = r.offer.kind;
        end
        return w;
    endfunction : read_word

    ////////////////////////////////////////////////////////////////////////
    // non-maskable winner first, then the maskable arbiter
    always_comb begin
        cand = '0;
        if (s.rst_pend) begin
            cand = '{1'b1, K_RESET, 5'h00, 4'hF, VEC_RESET};
        end else if (s.hw_pend != '0) begin
            for (int t = NUM_HWTRAP - 1; t >= 0; t--) begin
                if (s.hw_pend[t]) begin
                    cand = '{1'b1, K_HWTRAP, 5'(t), 4'hF,
                        16'(VEC_STEP * 16'(t + 1))};
                end
            end
        end else if (s.sw_pend != '0) begin
            for (int t = NUM_SWTRAP - 1; t >= 0; t--) begin
                if (s.sw_pend[t]) begin
                    cand = '{1'b1, K_SWTRAP, 5'(t), 4'hF,
                        16'(VEC_SWTRAP_BASE + VEC_STEP * 16'(t))};
                end
            end
        end else if (arb_found && arb_kind == K_EVENT) begin
            cand = '{1'b1, K_EVENT, arb_idx, arb_level,
                EVT_VEC[arb_idx[3:0]]};
        end else if (arb_found) begin
            cand = '{1'b1, K_SOFT, arb_idx, arb_level,
                16'(VEC_SOFT_BASE + VEC_STEP * 16'(arb_idx))};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb begin
        logic [7:0] pa_k;
        logic [7:0] wa;
        pa_k = 8'h00;
        wa = s.ph_addr;
        next_s = s;
        // pin synchronisers, second stage feeds all logic
        next_s.pin_s1 = {ext1_pin_n, ext0_pin_n, timer2_capture_pin};
        next_s.pin_s2 = s.pin_s1;
        next_s.t2_prev = s.pin_s2[0];
        // acknowledge drops the served non-maskable or soft request
        if (acked) begin
            case (s.offer.kind)
                K_RESET: next_s.rst_pend = 1'b0;
                K_HWTRAP: next_s.hw_pend[s.offer.idx[2:0]] = 1'b0;
                K_SWTRAP: next_s.sw_pend[s.offer.idx[3:0]] = 1'b0;
                K_SOFT: next_s.soft_req[s.offer.idx[2:0]] = 1'b0;
                K_EVENT: begin
                    if (s.offer.idx == 5'(EVT_TIMER2)) next_s.t2_ext_flag = 1'b0;
                end
                default: next_s.rst_pend = s.rst_pend;
            endcase
        end
        // new sources win over a same-cycle clear
        if (exc_in.reset_req) next_s.rst_pend = 1'b1;
        next_s.hw_pend = next_s.hw_pend | exc_in.hw_trap;
        if (exc_in.sw_trap) next_s.sw_pend[exc_in.sw_trap_num] = 1'b1;
        if (s.ctrl[CTRL_T2_BAUD] && t2_fall) next_s.t2_ext_flag = 1'b1;
        // data phase write; software set also beats an acknowledge clear
        if (s.ph_valid && s.ph_write) begin
            pa_k = (wa - OFS_PA_BASE) >> 2;
            if (wa == OFS_EN_LOW) next_s.en_low = hwdata[7:0];
            else if (wa == OFS_EN_HIGH) next_s.en_high = hwdata[7:0];
            else if (wa >= OFS_PA_BASE && wa <= OFS_PA_LAST
                && pa_k != 8'(PA_MISSING)) begin
                next_s.pa[pa_k[2:0]] = hwdata[7:0] & 8'h77;
            end else if (wa == OFS_SOFT_REQ) next_s.soft_req = hwdata[6:0];
            else if (wa == OFS_SOFT_EN) next_s.soft_en = hwdata[6:0];
            else if (wa == OFS_CTRL) next_s.ctrl = hwdata[2:0];
        end
        // address phase capture and read data
        next_s.ph_valid = hsel && htrans[1] && hready;
        next_s.ph_write = hwrite;
        next_s.ph_addr = haddr[7:0] & 8'hFC;
        if (hsel && htrans[1] && hready && !hwrite) begin
            next_s.rdata = read_word(s, haddr[7:0] & 8'hFC, evt_req);
        end
        // power-down wake from level-sensitive enabled external inputs
        next_s.wake = power_down && s.en_low[GLOBAL_EN_BIT] && ((s.ctrl[CTRL_EXT0_LVL]
            && s.en_low[EN_EXT0_BIT] && !s.pin_s2[1]) || (s.ctrl[CTRL_EXT1_LVL]
            && s.en_low[EN_EXT1_BIT] && !s.pin_s2[2]));
        // offer sequencing; the gap lets the core raise its level
        case (s.fsm)
            S_IDLE: begin
                next_s.offer = cand;
                if (cand.req) next_s.fsm = S_OFFER;
            end
            S_OFFER: begin
                if (core_in.ack) begin
                    next_s.offer.req = 1'b0;
                    next_s.fsm = S_GAP;
                end else begin
                    next_s.offer = cand;
                    if (!cand.req) next_s.fsm = S_IDLE;
                end
            end
            S_GAP: next_s.fsm = S_IDLE;
            default: next_s.fsm = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // state register; reset leaves every maskable enable clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s <= '0;
        end else if (ce) begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_reset_first: assert property (s.rst_pend && s.fsm == S_IDLE && ce ##1 ce
        |-> s.offer.kind == K_RESET && s.offer.vector == VEC_RESET)
        else $error("reset exception not offered first");
    a_soft_vector: assert property (s.offer.req && s.offer.kind == K_SOFT
        |-> s.offer.vector == 16'h0100 + 16'(s.offer.idx) * 16'h4
        && s.offer.level == 4'(s.offer.idx) + 4'h1)
        else $error("software interrupt vector or level wrong");
    a_event_band: assert property (s.offer.req && s.offer.kind == K_EVENT
        |-> s.offer.level >= LVL_EVT_LOW)
        else $error("event offered below its band");
    a_soft_band: assert property (s.offer.req && s.offer.kind == K_SOFT
        |-> s.offer.level <= LVL_SOFT_TOP && s.offer.level != 4'h0)
        else $error("software interrupt outside levels 1 to 7");
    a_global_gate: assert property (s.offer.req && s.offer.kind == K_EVENT
        && $past(ce) |-> $past(s.en_low[GLOBAL_EN_BIT]))
        else $error("event offered with global enable clear");
    a_above_core: assert property (s.offer.req && s.offer.kind == K_EVENT
        && $past(ce) && $past(s.fsm) != S_GAP |-> s.offer.level > $past(core_in.level))
        else $error("event offered at or below core level");
    a_ack_drop: assert property (acked && ce |=> !s.offer.req ##1 ce)
        else $error("request not dropped after acknowledge");
    a_trap_vector: assert property (s.offer.req && s.offer.kind == K_SWTRAP
        |-> s.offer.vector[15:6] == 10'h001 && s.offer.vector[5:2] == s.offer.idx[3:0])
        else $error("software trap vector wrong");
    a_hwtrap_vec: assert property (s.offer.req && s.offer.kind == K_HWTRAP
        |-> s.offer.vector == {9'h000, s.offer.idx + 5'h1, 2'b00})
        else $error("hardware trap vector wrong");
    a_t2_capture: assert property (ce && s.ctrl[CTRL_T2_BAUD] && t2_fall
        |=> s.t2_ext_flag)
        else $error("capture pin edge lost");
    a_wake_gate: assert property (s.wake |-> $past(power_down)
        && $past(s.ctrl[2:1]) != 2'b00)
        else $error("wake without level-sensitive input");

    c_preempt: cover property (s.offer.req && s.offer.kind == K_EVENT ##1
        s.offer.req && s.offer.level > $past(s.offer.level));
    c_soft_taken: cover property (acked && s.offer.kind == K_SOFT);
    c_trap_taken: cover property (acked && s.offer.kind == K_SWTRAP);
    c_wake: cover property (s.wake);
endmodule : pvic_top
`default_nettype wire

// ---- sim/pvic_core_model.sv ----
// core sequencer and peripheral event sources facing the controller
// assumes the offer is registered on hclk like this model
`timescale 1ns/1ps
`default_nettype none
module pvic_core_model (
    input wire logic hclk,
    input wire logic hresetn,
    input wire pvic_pkg::pvic_offer_t offer,
    input wire logic [12:0] raise,
    input wire logic ret,
    input wire logic rs,
    input wire logic [3:0] delay,
    output pvic_pkg::pvic_core_t core,
    output logic [12:0] flags,
    output pvic_pkg::pvic_offer_t taken,
    output int cnt
);
    import pvic_pkg::*;
    logic [3:0] wt;
    ////////////////////////////////////////////////////////////////
    // flags stay up until serviced; ack after a chosen wait
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            core <= '0;
            flags <= '0;
            taken <= '0;
            cnt <= 0;
            wt <= 4'h0;
        end else begin
            flags <= flags | raise;
            wt <= offer.req ? wt + 4'h1 : 4'h0;
            if (core.ack) begin
                // offer seen at the ack edge is the one entered
                core.ack <= 1'b0;
                taken <= offer;
                cnt <= cnt + 1;
                wt <= 4'h0;
                if (offer.kind == K_EVENT)
                    flags[offer.idx] <= 1'b0; // handler clears its source
                if (rs)
                    core.level <= offer.level;
            end else if (offer.req && wt >= delay) begin
                core.ack <= 1'b1;
            end
            // return from handler drops back to base level
            if (ret)
                core.level <= 4'h0;
        end
    end
endmodule : pvic_core_model
`default_nettype wire

// ---- sim/prioritized_vectored_interrupt_ctrl_test.sv ----
// register and take-order tests for the interrupt controller
// assumes pvic_core_model as core and flag sources; ce held high
`timescale 1ns/1ps
`default_nettype none
module prioritized_vectored_interrupt_ctrl_test;
    import pvic_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, ret, rs, tpin, x0n, pd, wake;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [3:0] delay;
    logic [12:0] raise, flags;
    pvic_exc_t exc;
    pvic_core_t core;
    pvic_offer_t offer, taken;
    int cnt, seen, bad_count, checks, cyc;
    logic [15:0] ev [13] = '{16'h0080, 16'h0084, 16'h0088, 16'h008C, 16'h0090,
        16'h0094, 16'h00A0, 16'h00A4, 16'h00AC, 16'h00B0, 16'h00B4, 16'h00B8, 16'h00BC};
    ////////////////////////////////////////////////////////////////
    pvic_top u_pvic_top (.hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .evt_flags(flags), .exc_in(exc),
        .core_in(core), .offer_out(offer), .timer2_capture_pin(tpin),
        .ext0_pin_n(x0n), .ext1_pin_n(1'b1), .power_down(pd), .wake_request(wake));
    pvic_core_model u_pvic_core_model (.hclk(hclk), .hresetn(hresetn), .offer(offer),
        .raise(raise), .ret(ret), .rs(rs), .delay(delay), .core(core),
        .flags(flags), .taken(taken), .cnt(cnt));
    ////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end
    // hang guard, well above the whole run
    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end
    ////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // one single word transfer; waits out any stall
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        q = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, q);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : rd
    // next entry into the core, in order of arrival
    task automatic take(input logic [15:0] v, input pvic_kind_t k, input logic [3:0] l);
        while (cnt <= seen) @(posedge hclk);
        seen++;
        chk("vector", {16'h0, v}, {16'h0, taken.vector});
        chk("kind", {29'h0, k}, {29'h0, taken.kind});
        chk("level", {28'h0, l}, {28'h0, taken.level});
    endtask : take
    task automatic none(input int n);
        repeat (n) @(posedge hclk);
        chk("take count", 32'(seen), 32'(cnt));
    endtask : none
    task automatic up(input logic [12:0] m);
        @(posedge hclk);
        raise <= m;
        @(posedge hclk);
        raise <= 13'h0;
    endtask : up
    task automatic pulse(input pvic_exc_t e);
        @(posedge hclk);
        exc <= e;
        @(posedge hclk);
        exc <= '0;
    endtask : pulse
    task automatic back();
        @(posedge hclk);
        ret <= 1'b1;
        @(posedge hclk);
        ret <= 1'b0;
    endtask : back
    ////////////////////////////////////////////////////////////////
    initial begin
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        exc = '0;
        raise = 13'h0;
        {ret, rs, pd} = 3'h0;
        {tpin, x0n} = 2'h3;
        delay = 4'h0;
        hresetn = 1'b0;
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        for (int a = 0; a < 64; a += 4) rd(8'(a), 32'h0);
        wr(8'h08, 32'hFF);
        rd(8'h08, 32'h77);
        wr(8'h14, 32'hFF);
        rd(8'h14, 32'h0);
        $display("test registers done");
        pulse('{1'b1, 5'h1F, 1'b1, 4'h5});
        take(16'h0000, K_RESET, 4'hF);
        for (int i = 0; i < 5; i++) take(16'(4 + 4 * i), K_HWTRAP, 4'hF);
        take(16'h0054, K_SWTRAP, 4'hF);
        for (int n = 0; n < 16; n++) begin
            pulse('{1'b0, 5'h0, 1'b1, 4'(n)});
            take(16'(64 + 4 * n), K_SWTRAP, 4'hF);
        end
        $display("test traps done");
        wr(8'h00, 32'hFF);
        wr(8'h04, 32'hFF);
        for (int a = 8; a < 40; a += 4) wr(8'(a), 32'h11);
        up(13'h1FFF);
        for (int i = 0; i < 13; i++) take(ev[i], K_EVENT, 4'h9);
        delay <= 4'h3;
        wr(8'h08, 32'h21);
        wr(8'h24, 32'h71);
        up(13'h1803);
        take(16'h00BC, K_EVENT, 4'hF);
        take(16'h0084, K_EVENT, 4'hA);
        take(16'h0080, K_EVENT, 4'h9);
        take(16'h00B8, K_EVENT, 4'h9);
        $display("test ranking done");
        wr(8'h08, 32'h10);
        up(13'h0001);
        none(30);
        wr(8'h00, 32'h7F);
        wr(8'h08, 32'h11);
        none(30);
        wr(8'h00, 32'hFE);
        none(30);
        wr(8'h00, 32'hFF);
        take(16'h0080, K_EVENT, 4'h9);
        $display("test masking done");
        delay <= 4'h0;
        rs <= 1'b1;
        wr(8'h08, 32'h21);
        wr(8'h0C, 32'h22);
        wr(8'h2C, 32'h7F);
        wr(8'h28, 32'h44);
        take(16'h0118, K_SOFT, 4'h7);
        none(20);
        up(13'h0001);
        take(16'h0080, K_EVENT, 4'h9);
        up(13'h0002);
        take(16'h0084, K_EVENT, 4'hA);
        up(13'h0004);
        none(20);
        back();
        take(16'h0088, K_EVENT, 4'hA);
        back();
        take(16'h0108, K_SOFT, 4'h3);
        back();
        rs <= 1'b0;
        wr(8'h28, 32'h7F);
        for (int n = 7; n > 0; n--) take(16'(252 + 4 * n), K_SOFT, 4'(n));
        rd(8'h28, 32'h0);
        $display("test preemption done");
        wr(8'h34, 32'h1);
        wr(8'h00, 32'h90);
        wr(8'h10, 32'h01);
        tpin <= 1'b0;
        take(16'h0090, K_EVENT, 4'h9);
        tpin <= 1'b1;
        pd <= 1'b1;
        wr(8'h00, 32'h81);
        wr(8'h34, 32'h2);
        x0n <= 1'b0;
        repeat (6) @(posedge hclk);
        chk("wake", 32'h1, {31'h0, wake});
        wr(8'h34, 32'h0);
        repeat (6) @(posedge hclk);
        chk("wake", 32'h0, {31'h0, wake});
        $display("test pins done");
        report_and_stop();
    end
endmodule : prioritized_vectored_interrupt_ctrl_test
`default_nettype wire
